// File: bench/irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the interrupt controller
module irq_checker
  import irq_pkg::*;
(
  input wire logic           clk,
  input wire logic           rstn,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [7:0]     wb_adr_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire periph_events_s events,
  input wire logic [7:0]     port_latch,
  input wire logic [7:0]     pullup_on,
  input wire core_ctrl_s     core,
  input wire logic           irq_request,
  input wire logic [15:0]    irq_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // First cycle of a read of one register
  sequence s_rd(logic [7:0] a);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
  endsequence
  // A high-level take: the core takes a raised request carrying the high vector
  sequence s_high_taken;
    core.irq_taken && irq_request && irq_vector == VECTOR_HIGH;
  endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_two_reserved: assert property (s_rd(ADDR_CONTROL_TWO) |=>
    wb_dat_o[3] == 1'b0 && wb_dat_o[1] == 1'b0)
    else $error("unused control two bits read one");
  a_three_reserved: assert property (s_rd(ADDR_CONTROL_THREE) |=>
    wb_dat_o[5] == 1'b0 && wb_dat_o[2] == 1'b0)
    else $error("unused control three bits read one");
  a_rx_level: assert property (s_rd(ADDR_PERIPH_FLAGS) |=>
    wb_dat_o[RX_FULL_BIT] == $past(events.serial_rx_full, 2))
    else $error("receive flag not following buffer");
  a_tx_level: assert property (s_rd(ADDR_PERIPH_FLAGS) |=>
    wb_dat_o[TX_EMPTY_BIT] == $past(events.serial_tx_empty, 2))
    else $error("transmit flag not following buffer");
  a_vector_legal: assert property (irq_request |->
    irq_vector == VECTOR_HIGH || irq_vector == VECTOR_LOW)
    else $error("request with unknown vector");
  a_high_taken: assert property (s_high_taken |-> ##2 !irq_request)
    else $error("request stays after high take");
  a_pullup_follow: assert property (pullup_on != 8'h00 |->
    pullup_on == $past(port_latch))
    else $error("pull-ups differ from port latch");
  a_reset_idle: assert property ($rose(rstn) |-> !irq_request &&
    irq_vector == VECTOR_HIGH && !wb_ack_o)
    else $error("outputs not idle after reset");
endmodule
bind irq_control irq_checker u_irq_checker (.clk, .rstn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .events,
  .port_latch, .pullup_on, .core, .irq_request, .irq_vector);
`default_nettype wire

// File: bench/periph_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the core and the peripheral event sources
module periph_core_model
  import irq_pkg::*;
(
  input  wire logic       [7:0] pulse,
  input  wire logic             tmr0,
  input  wire ccp_mode_e        mode,
  input  wire logic             rx_full,
  input  wire logic             tx_empty,
  input  wire logic             take,
  input  wire logic             ret,
  input  wire logic             irq_request,
  output var  periph_events_s   events,
  output var  core_ctrl_s       core
);
  // Strobes follow the bench one cycle each, in flag bit order
  always_comb begin
    events.timer_zero_ovf       = tmr0;
    events.parallel_port_access = pulse[7];
    events.conversion_done      = pulse[6];
    events.sync_serial_done     = pulse[3];
    events.capture_event        = pulse[2] & (mode != CCP_COMPARE);
    events.compare_event        = pulse[2] & (mode == CCP_COMPARE);
    events.timer_two_match      = pulse[1];
    events.timer_one_ovf        = pulse[0];
    events.ccp_mode             = mode;
    events.serial_rx_full       = rx_full;
    events.serial_tx_empty      = tx_empty;
  end
  // The core only takes a request that is really raised
  always_comb begin
    core.irq_taken             = take & irq_request;
    core.return_from_irq_instr = ret;
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 0, pulse = 0, port_latch = 8'hA5, pullup_on, q, pen = 0;
  logic [3:0] sel = 0, upper = 0;
  logic [31:0] dat_i = 0, dat_o;
  logic tmr0 = 0, rx = 0, tx = 1, take = 0, ret = 0, pb_rd = 0, irq_req;
  logic [2:0] pins = 0;
  logic [15:0] vec;
  ccp_mode_e mode = CCP_OFF;
  periph_events_s events;
  core_ctrl_s core;
  int fails = 0, num_checks = 0;
  irq_control u_irq_control (.clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .events, .periph_enable(pen),
    .periph_priority(8'hFF), .ext_pins(pins), .upper_port_pins(upper),
    .port_b_data_read(pb_rd), .port_latch, .pullup_on, .core,
    .irq_request(irq_req), .irq_vector(vec));
  periph_core_model u_periph_core_model (.pulse, .tmr0, .mode,
    .rx_full(rx), .tx_empty(tx), .take, .ret, .irq_request(irq_req),
    .events, .core);
  // Clock at 250 MHz
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One-cycle strobes from the peripherals and the core
  task automatic fire(input logic [7:0] p, input logic t, k, r);
    @(posedge clk);
    pulse <= p;
    tmr0 <= t;
    take <= k;
    ret <= r;
    @(posedge clk);
    pulse <= 8'h00;
    {tmr0, take, ret} <= 3'b000;
    tick(2);
  endtask
  task automatic t_reset();
    rd(ADDR_CONTROL, RST_CONTROL);
    rd(ADDR_CONTROL_TWO, RST_CONTROL_TWO);
    rd(ADDR_CONTROL_THREE, RST_CONTROL_THREE);
    rd(ADDR_CORE_MODE, RST_CORE_MODE);
    rd(ADDR_PERIPH_FLAGS, 8'h10);
    chk(pullup_on, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_reserved();
    wr(ADDR_CONTROL_TWO, 8'h00);
    rd(ADDR_CONTROL_TWO, 8'h00);
    chk(pullup_on, port_latch);
    wr(ADDR_CONTROL_TWO, 8'hFF);
    rd(ADDR_CONTROL_TWO, MASK_CONTROL_TWO);
    chk(pullup_on, 8'h00);
    wr(ADDR_CONTROL_THREE, 8'hFF);
    rd(ADDR_CONTROL_THREE, MASK_CONTROL_THREE);
    wr(ADDR_CONTROL_THREE, RST_CONTROL_THREE);
    wr(ADDR_CORE_MODE, 8'hFF);
    rd(ADDR_CORE_MODE, MASK_CORE_MODE);
    wr(ADDR_CORE_MODE, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    $display("test reserved done");
  endtask
  task automatic t_flags();
    mode <= CCP_PWM;
    fire(8'hCF, 1'b0, 1'b0, 1'b0);
    rd(ADDR_PERIPH_FLAGS, 8'hDB);
    chk(irq_req, 1'b0);
    pen <= 8'h01;
    wr(ADDR_CONTROL, 8'h80);
    tick(1);
    chk(irq_req, 1'b0);
    wr(ADDR_CONTROL, 8'hC0);
    tick(1);
    chk(irq_req, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h10);
    mode <= CCP_CAPTURE;
    fire(8'h04, 1'b0, 1'b0, 1'b0);
    rd(ADDR_PERIPH_FLAGS, 8'h14);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    mode <= CCP_COMPARE;
    fire(8'h04, 1'b0, 1'b0, 1'b0);
    rd(ADDR_PERIPH_FLAGS, 8'h14);
    rx <= 1'b1;
    tx <= 1'b0;
    wr(ADDR_PERIPH_FLAGS, 8'hFF);
    rd(ADDR_PERIPH_FLAGS, 8'hEF);
    rx <= 1'b0;
    tx <= 1'b1;
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h10);
    $display("test flags done");
  endtask
  task automatic t_timer();
    wr(ADDR_CONTROL, 8'hA0);
    fire(8'h00, 1'b1, 1'b0, 1'b0);
    chk(irq_req, 1'b1);
    chk(vec, VECTOR_HIGH);
    rd(ADDR_CONTROL, 8'hA4);
    fire(8'h00, 1'b0, 1'b1, 1'b0);
    chk(irq_req, 1'b0);
    rd(ADDR_CONTROL, 8'h24);
    fire(8'h00, 1'b0, 1'b0, 1'b1);
    chk(irq_req, 1'b1);
    wr(ADDR_CONTROL, 8'h84);
    tick(2);
    chk(irq_req, 1'b0);
    wr(ADDR_CONTROL, 8'h00);
    $display("test timer done");
  endtask
  task automatic t_priority();
    wr(ADDR_CORE_MODE, 8'h80);
    wr(ADDR_CONTROL_THREE, 8'h88);
    wr(ADDR_CONTROL, 8'hC0);
    pins[1] <= 1'b1;
    tick(3);
    chk(irq_req, 1'b1);
    chk(vec, VECTOR_LOW);
    rd(ADDR_CONTROL_THREE, 8'h89);
    fire(8'h00, 1'b0, 1'b1, 1'b0);
    chk(irq_req, 1'b0);
    pins[0] <= 1'b1;
    tick(3);
    rd(ADDR_CONTROL, 8'h82);
    wr(ADDR_CONTROL_TWO, 8'hE5);
    pins[2] <= 1'b1;
    tick(2);
    pins[2] <= 1'b0;
    tick(2);
    rd(ADDR_CONTROL_THREE, 8'h8B);
    pins <= 3'b000;
    wr(ADDR_CONTROL_TWO, RST_CONTROL_TWO);
    wr(ADDR_CONTROL_THREE, RST_CONTROL_THREE);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CORE_MODE, 8'h00);
    $display("test priority done");
  endtask
  task automatic t_port();
    upper <= 4'h5;
    tick(3);
    rd(ADDR_CONTROL, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h01);
    @(posedge clk);
    pb_rd <= 1'b1;
    @(posedge clk);
    pb_rd <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    tick(2);
    rd(ADDR_CONTROL, 8'h00);
    $display("test port done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(12);
    rstn <= 1'b1;
    t_reset();
    t_reserved();
    t_flags();
    t_timer();
    t_priority();
    t_port();
    finish_test();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire

// File: design/irq_control.sv
// What this block does
// R01 - Flags set on their event whatever the enables say.
// R02 - Bit 7 is global enable, or high-priority enable in priority mode.
// R03 - Bit 6 enables peripherals, or low-priority ones in priority mode.
// R04 - Control bits 5,4,3 enable timer-0, pin A and port-change sources.
// R05 - Control bit 2 set on timer-0 overflow, held until software clears.
// R06 - Control bit 1 set on pin A event, held until software clears.
// R07 - Port-change flag set while upper port pins differ from last read.
// R08 - Reading the port data ends the mismatch so the flag can clear.
// R09 - Edge bits 6,5,4 pick rising (1) or falling (0); reset to 1.
// R10 - Bit 7 of control two disables all pull-ups, else latches decide.
// R11 - Control two bits 2,0 give timer-0 and port-change priority; reset 1.
// R12 - Control three bits 7,6 give pin C and pin B priority; reset 1.
// R13 - Control three bits 4,3 enable pin C and pin B; reset 0.
// R14 - Control three bits 1,0 set on pin C and pin B events.
// R15 - Unimplemented bits ignore writes and read zero.
// R16 - Peripheral bit 7 set on parallel-port access; absent on small variant.
// R17 - Peripheral bit 6 set when a conversion completes.
// R18 - Peripheral bit 5 read-only, shows receive buffer full.
// R19 - Peripheral bit 4 read-only, shows transmit buffer empty.
// R20 - Peripheral bit 3 set when a synchronous serial transfer completes.
// R21 - Peripheral bit 2 set on capture or compare match; unused in PWM.
// R22 - Peripheral bits 1,0 set on timer-2 match and timer-1 overflow.
// R23 - High priority vectors to 0008h, low to 0018h; compat mode all 0008h.
// R24 - Taking an interrupt clears its level's global enable; return sets it.
// R25 - Priority mode bit resets to 0, so priority bits have no effect.
// R26 - Request needs flag, enable, peripheral enable and level's enable.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module irq_control
  import irq_pkg::*;
#(
  parameter bit PARALLEL_PORT_PRESENT = 1'b1
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  // Wishbone classic slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  // Peripheral sources
  input  wire periph_events_s events,
  input  wire logic [7:0]     periph_enable,
  input  wire logic [7:0]     periph_priority,
  input  wire logic [2:0]     ext_pins,
  input  wire logic [3:0]     upper_port_pins,
  input  wire logic           port_b_data_read,
  input  wire logic [7:0]     port_latch,
  output logic      [7:0]     pullup_on,
  // Processor core
  input  wire core_ctrl_s     core,
  output logic                irq_request,
  output logic      [15:0]    irq_vector
);

  // Register state
  logic [7:0]  control;
  logic [7:0]  control_two;
  logic [7:0]  control_three;
  logic [7:0]  periph_flags;
  logic [7:0]  core_mode;
  logic [3:0]  port_last_read;
  logic [2:0]  pins_prev;
  logic        in_high_service;
  // Bus decode
  logic        bus_req;
  logic        wr_byte;
  logic        wr_control;
  logic        wr_control_two;
  logic        wr_control_three;
  logic        wr_periph;
  logic        wr_core_mode;
  logic [7:0]  wdata;
  // Source events and gating
  logic [2:0]  pin_edge;
  logic        port_mismatch;
  logic        prio_mode;
  logic [4:0]  core_active;
  logic [4:0]  core_prio;
  logic [7:0]  periph_active;
  logic        any_high;
  logic        any_low;
  logic        next_request;
  logic [15:0] next_vector;
  logic [7:0]  next_control;
  logic [7:0]  next_control_three;
  logic [7:0]  next_periph_flags;
  logic [7:0]  read_mux;
  logic        taking_high;
  // Merge a software write with hardware set events; set wins
  function automatic logic [7:0] merge_flags(input logic [7:0] current,
                                             input logic       write,
                                             input logic [7:0] data,
                                             input logic [7:0] mask,
                                             input logic [7:0] set);
    logic [7:0] base;
    base = write ? ((data & mask) | (current & ~mask)) : current;
    return base | set;
  endfunction
  // Selected edge on one external pin
  function automatic logic edge_seen(input logic prev,
                                     input logic now,
                                     input logic rising);
    return rising ? (~prev & now) : (prev & ~now);
  endfunction
  // Wishbone request and per-register write strobes
  assign bus_req          = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_byte          = bus_req & wb_we_i & wb_sel_i[0];
  assign wdata            = wb_dat_i[7:0];
  assign wr_control       = wr_byte & (wb_adr_i == ADDR_CONTROL);
  assign wr_control_two   = wr_byte & (wb_adr_i == ADDR_CONTROL_TWO);
  assign wr_control_three = wr_byte & (wb_adr_i == ADDR_CONTROL_THREE);
  assign wr_periph        = wr_byte & (wb_adr_i == ADDR_PERIPH_FLAGS);
  assign wr_core_mode     = wr_byte & (wb_adr_i == ADDR_CORE_MODE);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      ADDR_CONTROL:       read_mux = control;
      ADDR_CONTROL_TWO:   read_mux = control_two & MASK_CONTROL_TWO;    // [R15]
      ADDR_CONTROL_THREE: read_mux = control_three &
                                     MASK_CONTROL_THREE; // [R15]
      ADDR_PERIPH_FLAGS:  read_mux = periph_flags;
      ADDR_CORE_MODE:     read_mux = core_mode & MASK_CORE_MODE;
      default:            read_mux = 8'h00;
    endcase
  end

  // Registered read data, upper bits zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, read_mux};
    end
  end

  // Previous pin levels for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_prev <= 3'h0;
    end else begin
      pins_prev <= ext_pins;
    end
  end

  // Edge polarity per pin from the edge-select bits
  assign pin_edge[0] = edge_seen(pins_prev[0], ext_pins[0],
                                 control_two[PIN_A_EDGE_BIT]);   // [R09]
  assign pin_edge[1] = edge_seen(pins_prev[1], ext_pins[1],
                                 control_two[PIN_B_EDGE_BIT]);   // [R09]
  assign pin_edge[2] = edge_seen(pins_prev[2], ext_pins[2],
                                 control_two[PIN_C_EDGE_BIT]);   // [R09]

  // Snapshot of the upper port pins at each port data read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_last_read <= 4'h0;
    end else if (port_b_data_read) begin
      port_last_read <= upper_port_pins;                         // [R08]
    end
  end

  // Mismatch keeps setting the flag until a read resolves it
  assign port_mismatch = (upper_port_pins != port_last_read);    // [R07]
  // Priority mode bit, cleared at reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_mode <= RST_CORE_MODE;                                // [R25]
    end else if (wr_core_mode) begin
      core_mode <= wdata & MASK_CORE_MODE;                       // [R15]
    end
  end

  assign prio_mode = core_mode[PRIO_MODE_BIT];
  // Main control register next value: flags, enables, global bits
  always_comb begin
    logic [7:0] set;
    set = 8'h00;
    set[TMR0_FLAG_BIT]     = events.timer_zero_ovf;              // [R05]
    set[PIN_A_FLAG_BIT]    = pin_edge[0];                        // [R06]
    set[PORT_CHG_FLAG_BIT] = port_mismatch;                      // [R07]
    // Flags set regardless of any enable bit
    next_control = merge_flags(control, wr_control, wdata,
                               8'hFF, set);                      // [R01]
    // Taking an interrupt clears the enable of its level
    if (core.irq_taken && irq_request) begin
      if (!prio_mode || taking_high) begin
        next_control[GLOBAL_HIGH_BIT] = 1'b0;                    // [R24]
      end else begin
        next_control[PERIPH_LOW_BIT] = 1'b0;                     // [R24]
      end
    end else if (core.return_from_irq_instr) begin
      if (!prio_mode || in_high_service) begin
        next_control[GLOBAL_HIGH_BIT] = 1'b1;                    // [R24]
      end else begin
        next_control[PERIPH_LOW_BIT] = 1'b1;                     // [R24]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control <= RST_CONTROL;
    end else begin
      control <= next_control;
    end
  end

  // Second control register: pull-up, edges and priorities
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_two <= RST_CONTROL_TWO;                            // [R09] [R11]
    end else if (wr_control_two) begin
      control_two <= wdata & MASK_CONTROL_TWO;                   // [R15]
    end
  end

  // Third control register next value: pin B and C flags
  always_comb begin
    logic [7:0] set;
    set = 8'h00;
    set[PIN_C_FLAG_BIT] = pin_edge[2];                           // [R14]
    set[PIN_B_FLAG_BIT] = pin_edge[1];                           // [R14]
    next_control_three = merge_flags(control_three, wr_control_three,
                                     wdata, MASK_CONTROL_THREE,
                                     set);                       // [R01]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_three <= RST_CONTROL_THREE;                        // [R12] [R13]
    end else begin
      control_three <= next_control_three & MASK_CONTROL_THREE;  // [R15]
    end
  end

  // Peripheral flag register next value
  always_comb begin
    logic [7:0] set;
    set = 8'h00;
    set[PAR_PORT_BIT]   = events.parallel_port_access;           // [R16]
    set[CONV_DONE_BIT]  = events.conversion_done;                // [R17]
    set[SYNC_SER_BIT]   = events.sync_serial_done;               // [R20]
    set[CAP_CMP_BIT]    = (events.ccp_mode == CCP_CAPTURE &&
                           events.capture_event) ||
                          (events.ccp_mode == CCP_COMPARE &&
                           events.compare_event);                // [R21]
    set[TMR2_MATCH_BIT] = events.timer_two_match;                // [R22]
    set[TMR1_OVF_BIT]   = events.timer_one_ovf;                  // [R22]
    next_periph_flags = merge_flags(periph_flags, wr_periph, wdata,
                                    MASK_PERIPH_SW, set);        // [R01]
    // Serial buffer flags mirror the buffer state, writes ignored
    next_periph_flags[RX_FULL_BIT]  = events.serial_rx_full;     // [R18]
    next_periph_flags[TX_EMPTY_BIT] = events.serial_tx_empty;    // [R19]
    if (!PARALLEL_PORT_PRESENT) begin
      next_periph_flags[PAR_PORT_BIT] = 1'b0;                    // [R16]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_flags <= RST_PERIPH_FLAGS;
    end else begin
      periph_flags <= next_periph_flags;
    end
  end

  // Core sources: flag and own enable; order tmr0, pin A, port, pin B, pin C
  assign core_active[0] = control[TMR0_FLAG_BIT] &
                          control[TMR0_EN_BIT];                  // [R04]
  assign core_active[1] = control[PIN_A_FLAG_BIT] &
                          control[PIN_A_EN_BIT];                 // [R04]
  assign core_active[2] = control[PORT_CHG_FLAG_BIT] &
                          control[PORT_CHG_EN_BIT];              // [R04]
  assign core_active[3] = control_three[PIN_B_FLAG_BIT] &
                          control_three[PIN_B_EN_BIT];           // [R13]
  assign core_active[4] = control_three[PIN_C_FLAG_BIT] &
                          control_three[PIN_C_EN_BIT];           // [R13]
  // Pin A has no priority bit and is always high priority
  assign core_prio[0] = control_two[TMR0_PRIO_BIT];              // [R11]
  assign core_prio[1] = 1'b1;
  assign core_prio[2] = control_two[PORT_CHG_PRIO_BIT];          // [R11]
  assign core_prio[3] = control_three[PIN_B_PRIO_BIT];           // [R12]
  assign core_prio[4] = control_three[PIN_C_PRIO_BIT];           // [R12]
  // Peripheral sources: flag and enable from the enable register
  assign periph_active = periph_flags & periph_enable;           // [R26]
  // Level requests before the global gates
  always_comb begin
    any_high = 1'b0;
    any_low  = 1'b0;
    if (!prio_mode) begin
      // Compatibility: priority bits ignored, one level
      any_high = (|core_active) |
                 ((|periph_active) & control[PERIPH_LOW_BIT]);   // [R03] [R25]
    end else begin
      any_high = (|(core_active & core_prio)) |
                 (|(periph_active & periph_priority));
      any_low  = (|(core_active & ~core_prio)) |
                 (|(periph_active & ~periph_priority));
    end
  end

  // Global gating and vector choice
  always_comb begin
    next_request = 1'b0;
    next_vector  = VECTOR_HIGH;
    if (control[GLOBAL_HIGH_BIT]) begin                          // [R02]
      if (any_high) begin
        next_request = 1'b1;                                     // [R26]
        next_vector  = VECTOR_HIGH;                              // [R23]
      end else if (prio_mode && any_low &&
                   control[PERIPH_LOW_BIT]) begin                // [R03]
        next_request = 1'b1;                                     // [R26]
        next_vector  = VECTOR_LOW;                               // [R23]
      end
    end
  end

  // Registered request and vector toward the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_request <= 1'b0;
      irq_vector  <= VECTOR_HIGH;
    end else begin
      irq_request <= next_request;
      irq_vector  <= next_vector;
    end
  end

  assign taking_high = (irq_vector == VECTOR_HIGH);
  // Which level is in service, for the return instruction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_high_service <= 1'b0;
    end else if (core.irq_taken && irq_request) begin
      in_high_service <= taking_high;
    end else if (core.return_from_irq_instr && in_high_service) begin
      in_high_service <= 1'b0;
    end
  end

  // Pull-ups follow latches unless all are disabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullup_on <= 8'h00;
    end else begin
      pullup_on <= control_two[PULLUP_DIS_BIT] ? 8'h00 : port_latch; // [R10]
    end
  end

endmodule

`default_nettype wire

// File: design/irq_pkg.sv
package irq_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_CONTROL       = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_THREE = 8'h08;
  localparam logic [7:0] ADDR_PERIPH_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_CORE_MODE     = 8'h10;

  // Reset values
  localparam logic [7:0] RST_CONTROL       = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO   = 8'hF5;
  localparam logic [7:0] RST_CONTROL_THREE = 8'hC0;
  localparam logic [7:0] RST_PERIPH_FLAGS  = 8'h00;
  localparam logic [7:0] RST_CORE_MODE     = 8'h00;

  // Implemented, software-writable bit masks
  localparam logic [7:0] MASK_CONTROL_TWO   = 8'hF5;
  localparam logic [7:0] MASK_CONTROL_THREE = 8'hDB;
  localparam logic [7:0] MASK_PERIPH_SW     = 8'hCF;
  localparam logic [7:0] MASK_CORE_MODE     = 8'h80;

  // Field positions, main control register
  localparam int GLOBAL_HIGH_BIT   = 7;
  localparam int PERIPH_LOW_BIT    = 6;
  localparam int TMR0_EN_BIT       = 5;
  localparam int PIN_A_EN_BIT      = 4;
  localparam int PORT_CHG_EN_BIT   = 3;
  localparam int TMR0_FLAG_BIT     = 2;
  localparam int PIN_A_FLAG_BIT    = 1;
  localparam int PORT_CHG_FLAG_BIT = 0;
  // Second control register
  localparam int PULLUP_DIS_BIT    = 7;
  localparam int PIN_A_EDGE_BIT    = 6;
  localparam int PIN_B_EDGE_BIT    = 5;
  localparam int PIN_C_EDGE_BIT    = 4;
  localparam int TMR0_PRIO_BIT     = 2;
  localparam int PORT_CHG_PRIO_BIT = 0;
  // Third control register
  localparam int PIN_C_PRIO_BIT    = 7;
  localparam int PIN_B_PRIO_BIT    = 6;
  localparam int PIN_C_EN_BIT      = 4;
  localparam int PIN_B_EN_BIT      = 3;
  localparam int PIN_C_FLAG_BIT    = 1;
  localparam int PIN_B_FLAG_BIT    = 0;
  // Peripheral flag register
  localparam int PAR_PORT_BIT      = 7;
  localparam int CONV_DONE_BIT     = 6;
  localparam int RX_FULL_BIT       = 5;
  localparam int TX_EMPTY_BIT      = 4;
  localparam int SYNC_SER_BIT      = 3;
  localparam int CAP_CMP_BIT       = 2;
  localparam int TMR2_MATCH_BIT    = 1;
  localparam int TMR1_OVF_BIT      = 0;
  // Core mode register
  localparam int PRIO_MODE_BIT     = 7;

  // Interrupt vectors
  localparam logic [15:0] VECTOR_HIGH = 16'h0008;
  localparam logic [15:0] VECTOR_LOW  = 16'h0018;

  // Capture/compare module operating mode
  typedef enum logic [1:0] {
    CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM
  } ccp_mode_e;

  // Event strobes and levels from the on-chip peripherals
  typedef struct packed {
    logic      timer_zero_ovf;
    logic      timer_one_ovf;
    logic      timer_two_match;
    logic      sync_serial_done;
    logic      conversion_done;
    logic      parallel_port_access;
    logic      capture_event;
    logic      compare_event;
    ccp_mode_e ccp_mode;
    logic      serial_rx_full;
    logic      serial_tx_empty;
  } periph_events_s;

  // Handshake from the processor core
  typedef struct packed {
    logic irq_taken;
    logic return_from_irq_instr;
  } core_ctrl_s;

endpackage
